/* rtl/pbd_pkg.sv */
// Package: address map, field layout and reset values of the peripheral base decoder
package pbd_pkg;
  localparam logic [23:0] BASE_ENTRY_ADDR = 24'h0000F0;
  localparam logic [23:0] BASE_REG_ADDR = 24'h0000F2;
  localparam logic [23:0] CTRL_REG_ADDR = 24'h0000F4;
  localparam logic [23:0] RSVD3_ADDR = 24'h0000F8;
  localparam logic [23:0] RSVD4_ADDR = 24'h0000FC;
  localparam logic [23:0] FIXED_LO_ADDR = 24'h0000F0;
  localparam logic [23:0] FIXED_HI_ADDR = 24'h0000FF;
  localparam logic [15:0] BASE_RESET = 16'hBFFF;
  localparam logic [31:0] CTRL_RESET = 32'h00000F00;
  localparam int SPACE_MSB = 15;
  localparam int SPACE_LSB = 13;
  localparam int CMP_EN_BIT = 12;
  localparam int ADDR_FIELD_MSB = 11;
  localparam int WIN_ADDR_LSB = 12;
  localparam int WIN_ADDR_MSB = 23;
  localparam logic [2:0] SUPER_DATA_SPACE = 3'h5;
  localparam logic [2:0] USER_DATA_SPACE = 3'h1;
  localparam logic [2:0] IACK_SPACE = 3'h7;
  // Control word: conflict flag and conflict bus-error enable
  localparam int CONFLICT_FLAG_BIT = 16;
  localparam int CONFLICT_EN_BIT = 17;
  // Host APB register offsets
  localparam logic [7:0] H_CMD_ADDR = 8'h00;
  localparam logic [7:0] H_SPACE = 8'h04;
  localparam logic [7:0] H_WDATA = 8'h08;
  localparam logic [7:0] H_CTRL = 8'h0C;
  localparam logic [7:0] H_RDATA = 8'h10;
  localparam logic [7:0] H_STATUS = 8'h14;
  localparam logic [7:0] H_IRQ_EN = 8'h18;
  localparam logic [7:0] H_IRQ_CLR = 8'h1C;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_BYTE_BIT = 2;
  localparam int CTRL_EXT_BIT = 3;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_BUS_ERROR_LINE_BIT = 1;
  localparam int ST_NOACK_BIT = 2;
endpackage

/* rtl/pbd_bus_if.sv */
// Interface: system bus between a bus master and the peripheral base decoder
`timescale 1ns/1ps
`default_nettype none
interface pbd_bus_if;
  logic strobe;
  logic write;
  logic byte_mode;
  logic byte_hi;
  logic ext_claim;
  logic [23:0] addr;
  logic [2:0] bus_space_code;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  logic bus_error_line;
  logic internal_access_indicator;
  logic window_select;
  logic chip_select;
  logic [11:0] local_offset;
  modport device (input strobe, write, byte_mode, byte_hi, ext_claim, addr, bus_space_code,
    wdata, output rdata, ack, bus_error_line, internal_access_indicator, window_select,
    chip_select, local_offset);
  modport master (output strobe, write, byte_mode, byte_hi, ext_claim, addr, bus_space_code,
    wdata, input rdata, ack, bus_error_line, internal_access_indicator, window_select,
    chip_select, local_offset);
endinterface
`default_nettype wire

/* rtl/peripheral_base_decode.sv */
// Device end: base register, control word and window address matcher
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Four fixed entries at 0F0 to 0FC
// - Peripheral window 4K, base written in space 5
// - Base register is word at 0F2
// - No window response until base written
// - Fixed registers always answer in supervisor data space
// - Reset only on total system reset
// - Chip select negated on fixed entries
// - 8-bit bus: low byte write enables
// - Decode conflict sets flag, optional bus error
// - Base reads BFFF after reset, invalid
// - Base reachable in supervisor data space only
// - Top three bits hold window space code
// - Software never programs space code seven
// - Bit 12 enables space code compare
// - Low twelve bits match address 23..12
// - Internal access flag on any internal access
// - Control word resets to 0000_0F00
module peripheral_base_decode (
  // Clock and resets
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic HALT,
  // System bus
  pbd_bus_if.device BUS
);
  logic [15:0] base_r;
  logic [31:0] ctrl_r;
  logic valid_r;
  logic [15:0] rdata_r;
  logic ack_r;
  logic bus_error_line_r;
  logic iac_r;
  logic win_r;
  logic cs_r;
  logic [11:0] ofs_r;

  wire total_reset = RESET && HALT;
  wire super_data = BUS.bus_space_code == pbd_pkg::SUPER_DATA_SPACE;
  wire fixed_hit = BUS.addr >= pbd_pkg::FIXED_LO_ADDR && BUS.addr <= pbd_pkg::FIXED_HI_ADDR;
  wire base_hit = {BUS.addr[23:1], 1'b0} == pbd_pkg::BASE_REG_ADDR && super_data;
  wire ctrl_hi_hit = BUS.addr[23:1] == pbd_pkg::CTRL_REG_ADDR[23:1];
  wire ctrl_lo_hit = BUS.addr[23:1] == pbd_pkg::RSVD3_ADDR[23:1] - 23'h1;
  wire ctrl_hit = (ctrl_hi_hit || ctrl_lo_hit) && super_data;
  wire fixed_any = fixed_hit && super_data;
  wire addr_match = BUS.addr[pbd_pkg::WIN_ADDR_MSB:pbd_pkg::WIN_ADDR_LSB]
    == base_r[pbd_pkg::ADDR_FIELD_MSB:0];
  wire space_match = !base_r[pbd_pkg::CMP_EN_BIT]
    || BUS.bus_space_code == base_r[pbd_pkg::SPACE_MSB:pbd_pkg::SPACE_LSB];
  wire win_hit = valid_r && addr_match && space_match && !fixed_any;
  wire conflict = win_hit && BUS.ext_claim;
  wire take = BUS.strobe && !ack_r;
  wire hi_lane = !BUS.byte_mode || BUS.byte_hi;
  wire lo_lane = !BUS.byte_mode || !BUS.byte_hi;
  wire base_wr = take && BUS.write && base_hit;
  wire [15:0] base_nxt = {hi_lane ? BUS.wdata[15:8] : base_r[15:8],
    lo_lane ? BUS.wdata[7:0] : base_r[7:0]};
  wire valid_nxt = valid_r || (base_wr && lo_lane);
  wire [31:0] ctrl_wdata = ctrl_hi_hit ? {BUS.wdata, ctrl_r[15:0]} : {ctrl_r[31:16], BUS.wdata};
  wire [31:0] ctrl_flag = 32'h1 << pbd_pkg::CONFLICT_FLAG_BIT;
  wire [31:0] ctrl_wr_val = (ctrl_wdata & ~ctrl_flag) | (ctrl_r & ctrl_flag);
  wire [31:0] ctrl_nxt = (take && BUS.write && ctrl_hit ? ctrl_wr_val : ctrl_r)
    | (take && conflict ? ctrl_flag : 32'h0);
  wire [15:0] rd_sel = base_hit ? base_r
    : ctrl_hit ? (ctrl_hi_hit ? ctrl_r[31:16] : ctrl_r[15:0]) : 16'h0000;
  wire bus_error_line_nxt = conflict && ctrl_r[pbd_pkg::CONFLICT_EN_BIT];
  // Peripheral locations themselves sit outside; the window answers here
  wire resp = fixed_any || win_hit;

  // Configuration state clears only on reset with halt; RESET alone leaves it
  always_ff @(posedge CORE_CLK) begin
    if (total_reset) begin
      base_r <= pbd_pkg::BASE_RESET;
      ctrl_r <= pbd_pkg::CTRL_RESET;
      valid_r <= 1'b0;
    end else begin
      if (base_wr) begin
        base_r <= base_nxt;
      end
      ctrl_r <= ctrl_nxt;
      valid_r <= valid_nxt;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rdata_r <= 16'h0000;
      ack_r <= 1'b0;
      bus_error_line_r <= 1'b0;
      iac_r <= 1'b0;
      win_r <= 1'b0;
      cs_r <= 1'b0;
      ofs_r <= 12'h000;
    end else begin
      ack_r <= take && resp && !bus_error_line_nxt;
      bus_error_line_r <= take && bus_error_line_nxt;
      rdata_r <= take ? rd_sel : rdata_r;
      iac_r <= BUS.strobe && resp;
      win_r <= BUS.strobe && win_hit;
      cs_r <= BUS.strobe && !fixed_hit && !win_hit;
      ofs_r <= win_hit ? BUS.addr[11:0] : 12'h000;
    end
  end

  assign BUS.rdata = rdata_r;
  assign BUS.ack = ack_r;
  assign BUS.bus_error_line = bus_error_line_r;
  assign BUS.internal_access_indicator = iac_r;
  assign BUS.window_select = win_r;
  assign BUS.chip_select = cs_r;
  assign BUS.local_offset = ofs_r;
endmodule
`default_nettype wire

/* rtl/pbd_bus_master.sv */
// Master end: APB-commanded bus master driving the decoder's system bus
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pbd_bus_master #(
  parameter int TIMEOUT = 16
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Interrupt
  output logic IRQ,
  // System bus
  pbd_bus_if.master BUS
);
  typedef enum logic [1:0] {IDLE, WAIT, DONE} state_type;
  state_type state_r;
  logic [23:0] addr_r;
  logic [2:0] space_r;
  logic [15:0] wdata_r;
  logic [3:0] ctrl_r;
  logic [15:0] rdata_r;
  logic [2:0] status_r;
  logic [2:0] irq_en_r;
  logic [31:0] prdata_r;
  logic irq_r;
  logic [7:0] wait_r;

  wire acc = PSEL && PENABLE;
  wire wr = acc && PWRITE;
  wire go = wr && PADDR == pbd_pkg::H_CTRL && PWDATA[pbd_pkg::CTRL_GO_BIT]
    && state_r == IDLE;
  wire timeout = wait_r == 8'(TIMEOUT);
  wire fin = state_r == WAIT && (BUS.ack || BUS.bus_error_line || timeout);
  // Software must not pick space seven for the window; space is passed as given
  wire [2:0] ev = {fin && timeout && !BUS.ack && !BUS.bus_error_line,
    fin && BUS.bus_error_line, fin};
  wire clr = wr && PADDR == pbd_pkg::H_IRQ_CLR;
  wire [2:0] status_nxt = (status_r & ~(clr ? PWDATA[2:0] : 3'h0)) | ev;
  wire [31:0] rd_mux = PADDR == pbd_pkg::H_CMD_ADDR ? {8'h00, addr_r}
    : PADDR == pbd_pkg::H_SPACE ? {29'h0, space_r}
    : PADDR == pbd_pkg::H_WDATA ? {16'h0000, wdata_r}
    : PADDR == pbd_pkg::H_CTRL ? {28'h0, ctrl_r[3:1], state_r != IDLE}
    : PADDR == pbd_pkg::H_RDATA ? {16'h0000, rdata_r}
    : PADDR == pbd_pkg::H_STATUS ? {29'h0, status_r}
    : PADDR == pbd_pkg::H_IRQ_EN ? {29'h0, irq_en_r} : 32'h0;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state_r <= IDLE;
      addr_r <= 24'h000000;
      space_r <= pbd_pkg::SUPER_DATA_SPACE;
      wdata_r <= 16'h0000;
      ctrl_r <= 4'h0;
      rdata_r <= 16'h0000;
      status_r <= 3'h0;
      irq_en_r <= 3'h0;
      prdata_r <= 32'h0;
      irq_r <= 1'b0;
      wait_r <= 8'h00;
    end else begin
      if (wr && PADDR == pbd_pkg::H_CMD_ADDR) addr_r <= PWDATA[23:0];
      if (wr && PADDR == pbd_pkg::H_SPACE) space_r <= PWDATA[2:0];
      if (wr && PADDR == pbd_pkg::H_WDATA) wdata_r <= PWDATA[15:0];
      if (wr && PADDR == pbd_pkg::H_IRQ_EN) irq_en_r <= PWDATA[2:0];
      if (go) ctrl_r <= PWDATA[3:0];
      if (fin && BUS.ack && !ctrl_r[pbd_pkg::CTRL_WRITE_BIT]) rdata_r <= BUS.rdata;
      status_r <= status_nxt;
      irq_r <= |(status_nxt & irq_en_r);
      if (PSEL && !PENABLE) prdata_r <= rd_mux;
      wait_r <= state_r == WAIT ? wait_r + 8'h01 : 8'h00;
      unique case (state_r)
        IDLE: state_r <= go ? WAIT : IDLE;
        WAIT: state_r <= fin ? DONE : WAIT;
        DONE: state_r <= IDLE;
      endcase
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  assign IRQ = irq_r;
  // Strobe dropped in DONE so the device sees a gap between cycles
  assign BUS.strobe = state_r == WAIT;
  assign BUS.write = ctrl_r[pbd_pkg::CTRL_WRITE_BIT];
  assign BUS.byte_mode = ctrl_r[pbd_pkg::CTRL_BYTE_BIT];
  assign BUS.byte_hi = !addr_r[0];
  assign BUS.ext_claim = ctrl_r[pbd_pkg::CTRL_EXT_BIT] && state_r == WAIT;
  assign BUS.addr = addr_r;
  assign BUS.bus_space_code = space_r;
  assign BUS.wdata = wdata_r;
endmodule
`default_nettype wire

/* verification/pbd_assertions.sv */
// Checker: bus timing and decode relations between the two ends
`timescale 1ns/1ps
`default_nettype none
module pbd_assertions (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // System bus
  input wire logic strobe,
  input wire logic ext_claim,
  input wire logic [23:0] addr,
  input wire logic [2:0] bus_space_code,
  input wire logic ack,
  input wire logic bus_error_line,
  input wire logic internal_access_indicator,
  input wire logic window_select,
  input wire logic chip_select,
  input wire logic [11:0] local_offset
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  wire fix = strobe && addr[23:4] == 20'h0000F;
  wire sup = bus_space_code == pbd_pkg::SUPER_DATA_SPACE;
  wire cfg = strobe && addr >= pbd_pkg::BASE_REG_ADDR && addr < pbd_pkg::RSVD3_ADDR;
  // Two cycles, since the outputs are registered
  sequence fixed_req;
    fix [*2];
  endsequence
  sequence sup_fixed_req;
    (fix && sup) [*2];
  endsequence
  ack_pulse_a: assert property (ack |=> !ack) else $error("ack held");
  ack_cause_a: assert property (ack |-> $past(strobe)) else $error("ack unasked");
  answer_excl_a: assert property (!(ack && bus_error_line)) else $error("two answers");
  bus_error_line_cause_a: assert property (bus_error_line |-> $past(ext_claim))
    else $error("bus error without conflict");
  fixed_cs_a: assert property (fixed_req |-> !chip_select)
    else $error("select on fixed");
  window_cs_a: assert property (window_select |-> !chip_select)
    else $error("select in window");
  offset_route_a: assert property (window_select && $past(strobe) |->
    local_offset == $past(addr[11:0])) else $error("offset wrong");
  iac_fixed_a: assert property (sup_fixed_req |-> internal_access_indicator)
    else $error("no internal flag");
  space_refuse_a: assert property (cfg && !sup |=> !ack)
    else $error("user space answered");
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Testbench: APB-driven master and decoder joined over the system bus
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic halt = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, got;
  logic [2:0] st;
  logic pready, irq;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  pbd_bus_if bus ();
  peripheral_base_decode u_peripheral_base_decode (.CORE_CLK(clk), .RESET(rst), .HALT(halt),
    .BUS(bus.device));
  pbd_bus_master u_pbd_bus_master (.CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(), .IRQ(irq), .BUS(bus.master));
  pbd_assertions u_pbd_assertions (.CORE_CLK(clk), .RESET(rst), .strobe(bus.strobe),
    .ext_claim(bus.ext_claim), .addr(bus.addr), .bus_space_code(bus.bus_space_code),
    .ack(bus.ack), .bus_error_line(bus.bus_error_line), .window_select(bus.window_select),
    .internal_access_indicator(bus.internal_access_indicator), .chip_select(bus.chip_select),
    .local_offset(bus.local_offset));
  initial forever #25 clk = ~clk;
  // Ceiling well above the several hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (n_mismatch == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Idle edge first, so psel is never assigned twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Control: 1 go, 2 write, 4 byte, 8 conflict claim
  task automatic op(input logic [23:0] a, input logic [2:0] sp, input logic [15:0] d,
      input logic [3:0] c);
    apb(1'b1, pbd_pkg::H_IRQ_CLR, 32'h7);
    apb(1'b1, pbd_pkg::H_CMD_ADDR, {8'h00, a});
    apb(1'b1, pbd_pkg::H_SPACE, {29'h0, sp});
    apb(1'b1, pbd_pkg::H_WDATA, {16'h0, d});
    apb(1'b1, pbd_pkg::H_CTRL, {28'h0, c});
    rd = 32'h0;
    while (rd[2:0] == 3'h0) apb(1'b0, pbd_pkg::H_STATUS, 32'h0);
    st = rd[2:0];
    apb(1'b0, pbd_pkg::H_RDATA, 32'h0);
    got = {13'h0, st, rd[15:0]};
  endtask
  task automatic rst_pulse(input logic h);
    @(posedge clk);
    rst <= 1'b1;
    halt <= h;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    halt <= 1'b0;
  endtask
  // Done is set on every finish, so a refusal reads 5 and a bus error 3
  task automatic t_after_reset();
    op(24'h0000F2, 3'h5, 16'h0, 4'h1);
    chk(got, 32'h1BFFF);
    op(24'h0000F6, 3'h5, 16'h0, 4'h1);
    chk(got, 32'h10F00);
    op(24'h0000F8, 3'h5, 16'h0, 4'h1);
    chk(got, 32'h10000);
    op(24'h123456, 3'h5, 16'h0, 4'h1);
    chk({29'h0, st}, 32'h5);
    op(24'h0000F2, 3'h1, 16'h0, 4'h1);
    chk({29'h0, st}, 32'h5);
  endtask
  task automatic t_window();
    op(24'h0000F2, 3'h5, 16'h0123, 4'h3);
    chk({29'h0, st}, 32'h1);
    op(24'h123ABC, 3'h1, 16'h0, 4'h1);
    chk(got, 32'h10000);
    op(24'h124ABC, 3'h1, 16'h0, 4'h1);
    chk({29'h0, st}, 32'h5);
    op(24'h0000F2, 3'h5, 16'h0, 4'h1);
    chk(got, 32'h10123);
  endtask
  task automatic t_space_cmp();
    op(24'h0000F2, 3'h5, 16'hB123, 4'h3);
    op(24'h123000, 3'h5, 16'h0, 4'h1);
    chk({29'h0, st}, 32'h1);
    op(24'h123000, 3'h1, 16'h0, 4'h1);
    chk({29'h0, st}, 32'h5);
  endtask
  task automatic t_conflict();
    op(24'h123010, 3'h5, 16'h0, 4'h9);
    op(24'h0000F4, 3'h5, 16'h0, 4'h1);
    chk(got, 32'h10001);
    op(24'h0000F4, 3'h5, 16'h0002, 4'h3);
    op(24'h123010, 3'h5, 16'h0, 4'h9);
    chk({29'h0, st}, 32'h3);
    op(24'h0000F4, 3'h5, 16'h0000, 4'h3);
    op(24'h0000F4, 3'h5, 16'h0, 4'h1);
    chk(got, 32'h10001);
  endtask
  task automatic t_resets();
    rst_pulse(1'b0);
    op(24'h0000F2, 3'h5, 16'h0, 4'h1);
    chk(got, 32'h1B123);
    rst_pulse(1'b1);
    op(24'h0000F2, 3'h5, 16'h0, 4'h1);
    chk(got, 32'h1BFFF);
  endtask
  // Byte lane data repeated on both halves of the word
  task automatic t_byte();
    op(24'h0000F2, 3'h5, 16'h0101, 4'h7);
    op(24'h1FF000, 3'h1, 16'h0, 4'h1);
    chk({29'h0, st}, 32'h5);
    op(24'h0000F3, 3'h5, 16'h2323, 4'h7);
    op(24'h123000, 3'h1, 16'h0, 4'h1);
    chk({29'h0, st}, 32'h1);
  endtask
  task automatic t_irq();
    apb(1'b1, pbd_pkg::H_IRQ_EN, 32'h1);
    op(24'h0000F2, 3'h5, 16'h0, 4'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, pbd_pkg::H_IRQ_CLR, 32'h7);
    apb(1'b0, pbd_pkg::H_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, pbd_pkg::H_IRQ_EN, 32'h0);
    op(24'h0000F2, 3'h5, 16'h0, 4'h1);
    chk({31'h0, irq}, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    halt <= 1'b0;
    t_after_reset();
    t_window();
    t_space_cmp();
    t_conflict();
    t_resets();
    t_byte();
    t_irq();
    print_verdict();
  end
endmodule
`default_nettype wire
